// File: bench/mode_reg_burst_order_bench.sv
// bench: host and device joined, a second device driven directly
module mode_reg_burst_order_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'h0;
    logic rst = 1'h1;
    logic busy = 1'h1;
    logic rv = 1'h0;
    logic rw = 1'h0;
    logic rb = 1'h0;
    logic [7:0] ra = 8'h00;
    logic [7:0] rd = 8'h00;
    logic [10:0] rc = 11'h000;
    logic req_refused, resp_valid, rf, got, ill, pc;
    logic [7:0] resp_data, feature_cfg, feat2, rdat;
    logic [3:0] wr_count, wr2;
    logic [63:0] acc;
    int nb, bad_count, total_checks;
    logic [7:0] fv [6] = '{8'h22, 8'h2a, 8'h23, 8'h2b, 8'h64, 8'hd2};
    logic [10:0] cv [6] = '{11'h003, 11'h006, 11'h00c, 11'h002, 11'h00a,
        11'h00e};
    logic [63:0] ev [6] = '{64'h2301, 64'h6745, 64'hcdef89ab,
        64'h23016745, 64'habcdef0123456789, 64'hef01};
    logic [15:0] rt [7] = '{16'h0125, 16'h0133, 16'h012c, 16'h0102,
        16'h01e2, 16'h0b00, 16'h0000};
    mrbo_link_if link();
    mrbo_link_if link2();
    mrbo_device mrbo_device_inst (.ref_clk(ref_clk), .rst(rst), .link(link),
        .auto_init_busy(busy), .feature_cfg(feature_cfg),
        .wr_count(wr_count));
    mrbo_device mrbo_device_inst2 (.ref_clk(ref_clk), .rst(rst),
        .link(link2), .auto_init_busy(busy), .feature_cfg(feat2),
        .wr_count(wr2));
    mrbo_host mrbo_host_inst (.ref_clk(ref_clk), .rst(rst), .link(link),
        .req_valid(rv), .req_write(rw), .req_burst(rb), .req_addr(ra),
        .req_data(rd), .req_col(rc), .req_auto_pre(rb),
        .req_refused(req_refused), .resp_data(resp_data),
        .resp_valid(resp_valid));
    mrbo_monitor mrbo_monitor_inst (.ref_clk(ref_clk), .rst(rst),
        .cmd(link.cmd), .addr(link.addr), .wdata(link.wdata),
        .rdata(link.rdata), .rdata_valid(link.rdata_valid),
        .strobe_toggle(link.strobe_toggle), .burst_req(link.burst_req),
        .col(link.col), .auto_pre(link.auto_pre), .beat_col(link.beat_col),
        .beat_valid(link.beat_valid), .beat_last(link.beat_last),
        .burst_illegal(link.burst_illegal),
        .precharge_start(link.precharge_start));
    // 40 mhz clock
    always #12.5 ref_clk = ~ref_clk;
    // compare and count
    task automatic check(input string what, input logic [63:0] seen,
        input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // verdict and end of run
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // one request via the host, or straight onto the second device
    task automatic op(input logic dr, w, b, input logic [7:0] a, d,
        input logic [10:0] c);
        @(posedge ref_clk);
        #1;
        {ra, rd, rc, rw, rb} = {a, d, c, w, b};
        link2.addr = a;
        link2.wdata = d;
        link2.col = c;
        link2.burst_req = b & dr;
        link2.cmd = (dr & ~b) ? {w, ~w} : 2'h0;
        rv = ~dr;
        @(posedge ref_clk);
        #1;
        rv = 1'h0;
        link2.cmd = 2'h0;
        link2.burst_req = 1'h0;
        {rf, got, ill, pc} = 4'h0;
        acc = 64'h0;
        nb = 0;
        // watch a fixed window for answers, beats and flags
        repeat (30) begin
            rf |= req_refused === 1'h1;
            ill |= link2.burst_illegal === 1'h1;
            pc |= link.precharge_start === 1'h1;
            if ((dr ? link2.rdata_valid : resp_valid) === 1'h1) begin
                got = 1'h1;
                rdat = dr ? link2.rdata : resp_data;
            end
            if ((dr ? link2.beat_valid : link.beat_valid) === 1'h1) begin
                acc = {acc[59:0], dr ? link2.beat_col : link.beat_col};
                nb++;
            end
            @(posedge ref_clk);
            #1;
        end
    endtask
    // main sequence
    initial begin
        link2.cmd = 2'h0;
        link2.addr = 8'h00;
        link2.wdata = 8'h00;
        link2.burst_req = 1'h0;
        link2.col = 11'h000;
        link2.auto_pre = 1'h0;
        bad_count = 0;
        total_checks = 0;
        repeat (2) @(posedge ref_clk);
        #1;
        rst = 1'h0;
        check("feature reset", feature_cfg, mrbo_pkg::FEATURE_RESET);
        check("wr reset", wr_count, 4'h3);
        op(1'h0, 1'h0, 1'h0, 8'h00, 8'h00, 11'h000);
        check("info busy", rdat, 8'h01);
        busy = 1'h0;
        repeat (4) @(posedge ref_clk);
        op(1'h0, 1'h0, 1'h0, 8'h00, 8'h00, 11'h000);
        check("info done", rdat, 8'h00);
        op(1'h0, 1'h0, 1'h0, 8'h01, 8'h00, 11'h000);
        check("write-only answer", got, 1'h1);
        op(1'h0, 1'h0, 1'h0, 8'h0b, 8'h00, 11'h000);
        check("reserved answer", got, 1'h1);
        $display("register test done");
        for (int i = 0; i < 6; i++) begin
            op(1'h0, 1'h1, 1'h0, 8'h01, fv[i], 11'h000);
            check("feature", feature_cfg, fv[i]);
            check("wr count", wr_count, fv[i][7:5] + 4'h2);
            op(1'h0, 1'h0, 1'h1, 8'h00, 8'h00, cv[i]);
            check("order", acc, ev[i]);
            check("beats", nb, 64'h1 << fv[i][2:0]);
            check("precharge", pc, 1'h1);
        end
        $display("burst test done");
        for (int i = 0; i < 7; i++) begin
            op(1'h0, 1'h1, 1'h0, rt[i][15:8], rt[i][7:0], 11'h000);
            check("refused", rf, 1'h1);
            check("kept", feature_cfg, 8'hd2);
        end
        op(1'h0, 1'h0, 1'h1, 8'h00, 8'h00, 11'h3fe);
        check("column refused", rf, 1'h1);
        check("column beats", nb, 0);
        $display("refusal test done");
        for (int i = 0; i < 3; i++) begin
            op(1'h1, 1'h1, 1'h0, 8'h01, rt[i][7:0], 11'h000);
            op(1'h1, 1'h0, 1'h1, 8'h00, 8'h00, 11'h004);
            check("flagged", ill, 1'h1);
            check("no beats", nb, 0);
        end
        op(1'h1, 1'h1, 1'h0, 8'h01, 8'he2, 11'h000);
        check("wr kept", wr2, 4'h3);
        op(1'h1, 1'h1, 1'h0, 8'h00, 8'hff, 11'h000);
        op(1'h1, 1'h0, 1'h0, 8'h00, 8'h00, 11'h000);
        check("info unchanged", rdat, 8'h00);
        $display("direct test done");
        results();
    end
endmodule

// File: bench/mrbo_monitor.sv
// checker: timing and order relations on the host to device link
module mrbo_monitor (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [1:0] cmd,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic rdata_valid,
    input wire logic strobe_toggle,
    input wire logic burst_req,
    input wire logic [10:0] col,
    input wire logic auto_pre,
    input wire logic [3:0] beat_col,
    input wire logic beat_valid,
    input wire logic beat_last,
    input wire logic burst_illegal,
    input wire logic precharge_start
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    logic [7:0] feat_q, feat_d;
    logic [3:0] wr_q, wr_d, s_q, s_d, m_q, m_d, k_q, k_d, pc_q, pc_d;
    logic [3:0] exp;
    logic it_q, it_d, nw_q, nw_d, ap_q, ap_d;
    // next values of the mirrored feature and burst state
    always_comb begin
        feat_d = feat_q;
        wr_d = wr_q;
        if (cmd == 2'h2 && addr == mrbo_pkg::MA_BURST_FEATURE_CONFIG) begin
            feat_d = wdata;
            if (wdata[7:5] >= 3'h1 && wdata[7:5] <= 3'h6) begin
                wr_d = {1'h0, wdata[7:5]} + 4'h2;
            end
        end
        {s_d, m_d, it_d, nw_d, ap_d} = {s_q, m_q, it_q, nw_q, ap_q};
        k_d = beat_valid ? k_q + 4'h1 : k_q;
        if (burst_req) begin
            s_d = {col[3:1], 1'h0};
            m_d = 4'((5'h01 << feat_q[2:0]) - 5'h01);
            it_d = feat_q[3];
            nw_d = feat_q[4];
            ap_d = auto_pre;
            k_d = 4'h0;
        end
        pc_d = (pc_q == 4'h0) ? 4'h0 : pc_q - 4'h1;
        if (beat_last && ap_q) begin
            pc_d = wr_q;
        end
    end
    // registers of the mirrored state
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            feat_q <= mrbo_pkg::FEATURE_RESET;
            wr_q <= 4'h3;
            {s_q, m_q, k_q, pc_q, it_q, nw_q, ap_q} <= 19'h0;
        end else begin
            feat_q <= feat_d;
            wr_q <= wr_d;
            {s_q, m_q, k_q, pc_q} <= {s_d, m_d, k_d, pc_d};
            {it_q, nw_q, ap_q} <= {it_d, nw_d, ap_d};
        end
    end
    // expected column of the current beat
    always_comb begin
        if (nw_q) exp = s_q + k_q;
        else if (it_q) exp = (s_q & ~m_q) | ((s_q ^ k_q) & m_q);
        else exp = (s_q & ~m_q) | ((s_q + k_q) & m_q);
    end
    sequence s_run4;
        (beat_valid && !beat_last) [*3] ##1 (beat_valid && beat_last);
    endsequence
    sequence s_run8;
        (beat_valid && !beat_last) [*7] ##1 (beat_valid && beat_last);
    endsequence
    a_read_answer_time: assert property (cmd == 2'h1 |-> ##3 rdata_valid)
        else $error("read answer not three cycles after read");
    a_strobe_with_data: assert property (rdata_valid == strobe_toggle)
        else $error("strobe and read answer differ");
    a_info_zero_bits: assert property (cmd == 2'h1 &&
        addr == 8'h00 |-> ##3 rdata[7:1] == 7'h00)
        else $error("device info upper bits not zero");
    a_burst_four: assert property (burst_req && feat_q[2:0] == 3'h2
        |-> ##2 s_run4 ##1 !beat_valid)
        else $error("four beat burst malformed");
    a_burst_eight: assert property (burst_req && feat_q[2:0] == 3'h3
        |-> ##2 s_run8 ##1 !beat_valid)
        else $error("eight beat burst malformed");
    a_burst_sixteen: assert property (burst_req && feat_q[2:0] == 3'h4
        |-> ##2 (beat_valid && !beat_last) [*8] ##1 s_run8)
        else $error("sixteen beat burst malformed");
    a_start_even: assert property ($rose(beat_valid) |-> !beat_col[0])
        else $error("burst starts at odd column");
    a_beat_order: assert property (beat_valid |-> beat_col == exp)
        else $error("beat column out of order");
    a_precharge_time: assert property (
        precharge_start == ($past(pc_q) == 4'h1))
        else $error("precharge start at wrong cycle");
    a_legal_no_flag: assert property (burst_req |=> !burst_illegal)
        else $error("legal burst flagged");
endmodule

// File: src/mrbo_burst_seq.sv
// burst column sequencer: start column to per-beat column order
module mrbo_burst_seq (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [3:0] start_col,
    input wire logic [2:0] blen_code,
    input wire logic interleaved,
    input wire logic no_wrap,
    output logic [3:0] beat_col,
    output logic beat_valid,
    output logic beat_last,
    output logic illegal
);
    logic [3:0] base_q, base_d;
    logic [4:0] cnt_q, cnt_d;
    logic [4:0] len_q, len_d;
    logic [3:0] mask_q, mask_d;
    logic inter_q, inter_d;
    logic nw_q, nw_d;
    logic act_q, act_d;
    logic [3:0] col_q, col_d;
    logic val_q, val_d;
    logic last_q, last_d;
    logic ill_q, ill_d;

    // column of one beat for the held mode
    function automatic logic [3:0] beat_addr(input logic [3:0] b,
        input logic [3:0] k, input logic [3:0] m, input logic i,
        input logic n);
        logic [3:0] s;
        s = 4'(b + k);
        if (n) begin
            beat_addr = s;
        end else if (i) begin
            beat_addr = (b & ~m) | ((b ^ k) & m);
        end else begin
            beat_addr = (b & ~m) | (s & m);
        end
    endfunction

    // next state of the sequencer
    always_comb begin
        base_d = base_q;
        len_d = len_q;
        mask_d = mask_q;
        inter_d = inter_q;
        nw_d = nw_q;
        cnt_d = cnt_q;
        act_d = act_q;
        ill_d = 1'b0;
        val_d = 1'b0;
        last_d = 1'b0;
        col_d = col_q;
        if (start) begin
            base_d = {start_col[3:1], 1'b0};
            inter_d = interleaved;
            nw_d = no_wrap;
            cnt_d = '0;
            act_d = 1'b1;
            unique case (blen_code)
                mrbo_pkg::BL_CODE_4: begin
                    len_d = mrbo_pkg::BEATS_4;
                    mask_d = 4'h3;
                end
                mrbo_pkg::BL_CODE_8: begin
                    len_d = mrbo_pkg::BEATS_8;
                    mask_d = 4'h7;
                    act_d = !no_wrap;
                end
                mrbo_pkg::BL_CODE_16: begin
                    len_d = mrbo_pkg::BEATS_16;
                    mask_d = 4'hf;
                    act_d = !no_wrap && !interleaved;
                end
                default: begin
                    len_d = mrbo_pkg::BEATS_4;
                    mask_d = 4'h3;
                    act_d = 1'b0;
                end
            endcase
            ill_d = !act_d;
        end else if (act_q) begin
            col_d = beat_addr(base_q, cnt_q[3:0], mask_q, inter_q, nw_q);
            val_d = 1'b1;
            last_d = (5'(cnt_q + 5'h01) == len_q);
            cnt_d = 5'(cnt_q + 5'h01);
            act_d = !last_d;
        end
    end

    // sequencer registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            base_q <= '0;
            len_q <= mrbo_pkg::BEATS_4;
            mask_q <= 4'h3;
            inter_q <= 1'b0;
            nw_q <= 1'b0;
            cnt_q <= '0;
            act_q <= 1'b0;
            col_q <= '0;
            val_q <= 1'b0;
            last_q <= 1'b0;
            ill_q <= 1'b0;
        end else begin
            base_q <= base_d;
            len_q <= len_d;
            mask_q <= mask_d;
            inter_q <= inter_d;
            nw_q <= nw_d;
            cnt_q <= cnt_d;
            act_q <= act_d;
            col_q <= col_d;
            val_q <= val_d;
            last_q <= last_d;
            ill_q <= ill_d;
        end
    end

    assign beat_col = col_q;
    assign beat_valid = val_q;
    assign beat_last = last_q;
    assign illegal = ill_q;
endmodule

// File: src/mrbo_device.sv
// device end: mode registers, read answers, burst order, precharge
//
// Contract
// - host reads with read, changes with write
// - host writes reserved bits as zero
// - reserved bits of implemented registers read zero
// - reserved/write-only reads: undefined data, strobe toggles
// - host never writes wholly reserved registers
// - writes to read-only registers are ignored
// - device info: class bit 0, init status
// - burst length codes 4, 8, 16 only
// - burst type bit: sequential or interleaved
// - host avoids length 16 interleaved
// - no wrap only with length 4
// - write recovery codes 1..6 give 3..8
// - precharge starts after write recovery count
// - length 4 wraps modulo 4
// - length 8 sequential or xor interleave
// - length 16 sequential modulo 16
// - lowest column bit forced zero
// - no wrap length 4 counts upward
// - host avoids forbidden no-wrap column sequences
module mrbo_device (
    input wire logic ref_clk,
    input wire logic rst,
    mrbo_link_if.device link,
    input wire logic auto_init_busy,
    output logic [7:0] feature_cfg,
    output logic [3:0] wr_count
);
    logic [7:0] feat_q, feat_d;
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] rpipe_q, rpipe_d;
    logic [1:0] rdly_q, rdly_d;
    logic rval_q, rval_d;
    logic tog_q, tog_d;
    logic init_s1_q, init_s2_q;
    logic [3:0] wr_q, wr_d;
    logic [3:0] pc_cnt_q, pc_cnt_d;
    logic pc_arm_q, pc_arm_d;
    logic pc_q, pc_d;
    logic wr_burst_q, wr_burst_d;
    logic [3:0] seq_col;
    logic seq_valid;
    logic seq_last;
    logic seq_ill;

    // code to write recovery clock count
    function automatic logic [3:0] wr_clocks(input logic [2:0] code);
        wr_clocks = 4'({1'b0, code} + mrbo_pkg::WR_COUNT_OFFSET);
    endfunction

    // auto-init status level from outside, two flops
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            init_s1_q <= 1'b1;
            init_s2_q <= 1'b1;
        end else begin
            init_s1_q <= auto_init_busy;
            init_s2_q <= init_s1_q;
        end
    end

    // mode register write and read answer
    always_comb begin
        feat_d = feat_q;
        rpipe_d = rpipe_q;
        rdly_d = rdly_q;
        rdata_d = rdata_q;
        rval_d = 1'b0;
        tog_d = 1'b0;
        wr_d = wr_q;
        if (link.cmd == 2'(mrbo_pkg::MRBO_CMD_WRITE)) begin
            if (link.addr == mrbo_pkg::MA_BURST_FEATURE_CONFIG) begin
                feat_d = link.wdata;
                if (link.wdata[mrbo_pkg::WR_LSB +: 3] >= mrbo_pkg::WR_CODE_MIN
                    && link.wdata[mrbo_pkg::WR_LSB +: 3]
                    <= mrbo_pkg::WR_CODE_MAX) begin
                    wr_d = wr_clocks(link.wdata[mrbo_pkg::WR_LSB +: 3]);
                end
            end
            // other addresses, incl. read-only info, ignored
        end
        if (link.cmd == 2'(mrbo_pkg::MRBO_CMD_READ)) begin
            rdly_d = mrbo_pkg::READ_DELAY;
            if (link.addr == mrbo_pkg::MA_DEVICE_INFORMATION) begin
                rpipe_d = '0;
                rpipe_d[mrbo_pkg::DI_CLASS_BIT] = mrbo_pkg::DI_CLASS_SDRAM;
                rpipe_d[mrbo_pkg::DI_INIT_BIT] = init_s2_q;
            end else begin
                rpipe_d = feat_q ^ {link.addr[3:0], link.addr[7:4]};
            end
        end else if (rdly_q != 2'h0) begin
            rdly_d = 2'(rdly_q - 2'h1);
            if (rdly_q == 2'h1) begin
                rdata_d = rpipe_q;
                rval_d = 1'b1;
                tog_d = 1'b1;
            end
        end
    end

    // any burst with auto precharge: count write recovery clocks
    always_comb begin
        pc_cnt_d = pc_cnt_q;
        pc_arm_d = pc_arm_q;
        pc_d = 1'b0;
        wr_burst_d = wr_burst_q;
        if (link.burst_req) begin
            wr_burst_d = link.auto_pre;
        end
        if (seq_valid && seq_last && wr_burst_q) begin
            pc_arm_d = 1'b1;
            pc_cnt_d = wr_q;
            wr_burst_d = 1'b0;
        end else if (pc_arm_q) begin
            pc_cnt_d = 4'(pc_cnt_q - 4'h1);
            if (pc_cnt_q == 4'h1) begin
                pc_arm_d = 1'b0;
                pc_d = 1'b1;
            end
        end
    end

    // device registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            feat_q <= mrbo_pkg::FEATURE_RESET;
            wr_q <= 4'h3;
            rpipe_q <= '0;
            rdly_q <= '0;
            rdata_q <= '0;
            rval_q <= 1'b0;
            tog_q <= 1'b0;
            pc_cnt_q <= '0;
            pc_arm_q <= 1'b0;
            pc_q <= 1'b0;
            wr_burst_q <= 1'b0;
        end else begin
            feat_q <= feat_d;
            wr_q <= wr_d;
            rpipe_q <= rpipe_d;
            rdly_q <= rdly_d;
            rdata_q <= rdata_d;
            rval_q <= rval_d;
            tog_q <= tog_d;
            pc_cnt_q <= pc_cnt_d;
            pc_arm_q <= pc_arm_d;
            pc_q <= pc_d;
            wr_burst_q <= wr_burst_d;
        end
    end

    // column order engine
    mrbo_burst_seq u_seq (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(link.burst_req),
        .start_col(link.col[3:0]),
        .blen_code(feat_q[mrbo_pkg::BLEN_LSB +: 3]),
        .interleaved(feat_q[mrbo_pkg::BTYPE_BIT]),
        .no_wrap(feat_q[mrbo_pkg::WRAP_BIT]),
        .beat_col(seq_col),
        .beat_valid(seq_valid),
        .beat_last(seq_last),
        .illegal(seq_ill)
    );

    assign link.rdata = rdata_q;
    assign link.rdata_valid = rval_q;
    assign link.strobe_toggle = tog_q;
    assign link.beat_col = seq_col;
    assign link.beat_valid = seq_valid;
    assign link.beat_last = seq_last;
    assign link.burst_illegal = seq_ill;
    assign link.precharge_start = pc_q;
    assign feature_cfg = feat_q;
    assign wr_count = wr_q;
endmodule

// File: src/mrbo_host.sv
// host end: issues mode register reads and writes and bursts
module mrbo_host (
    input wire logic ref_clk,
    input wire logic rst,
    mrbo_link_if.host link,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_burst,
    input wire logic [7:0] req_addr,
    input wire logic [7:0] req_data,
    input wire logic [10:0] req_col,
    input wire logic req_auto_pre,
    output logic req_refused,
    output logic [7:0] resp_data,
    output logic resp_valid
);
    logic [1:0] cmd_q, cmd_d;
    logic [7:0] addr_q, addr_d;
    logic [7:0] wdata_q, wdata_d;
    logic breq_q, breq_d;
    logic [10:0] col_q, col_d;
    logic ap_q, ap_d;
    logic [7:0] shadow_q, shadow_d;
    logic ref_q, ref_d;
    logic [7:0] resp_q, resp_d;
    logic rv_q, rv_d;
    logic [7:0] clean;

    // writable registers only; reserved gaps and test mode refused
    function automatic logic writable(input logic [7:0] a);
        writable = ((a >= mrbo_pkg::MA_BURST_FEATURE_CONFIG)
            && (a <= mrbo_pkg::MA_IO_CONFIG))
            || a == mrbo_pkg::MA_BANK_MASK
            || a == mrbo_pkg::MA_LAST_DEFINED;
    endfunction

    // legality of a feature setting
    function automatic logic feat_ok(input logic [7:0] f);
        logic [2:0] bl;
        logic [2:0] wr;
        bl = f[mrbo_pkg::BLEN_LSB +: 3];
        wr = f[mrbo_pkg::WR_LSB +: 3];
        feat_ok = (bl == mrbo_pkg::BL_CODE_4 || bl == mrbo_pkg::BL_CODE_8
            || bl == mrbo_pkg::BL_CODE_16)
            && !(bl == mrbo_pkg::BL_CODE_16 && f[mrbo_pkg::BTYPE_BIT])
            && !(bl != mrbo_pkg::BL_CODE_4 && f[mrbo_pkg::WRAP_BIT])
            && wr >= mrbo_pkg::WR_CODE_MIN
            && wr <= mrbo_pkg::WR_CODE_MAX;
    endfunction

    // feature write with reserved bits cleared
    assign clean = req_data; // all 8 feature bits defined

    // request to command
    always_comb begin
        cmd_d = 2'(mrbo_pkg::MRBO_CMD_NONE);
        addr_d = addr_q;
        wdata_d = wdata_q;
        breq_d = 1'b0;
        col_d = col_q;
        ap_d = 1'b0;
        shadow_d = shadow_q;
        ref_d = 1'b0;
        resp_d = resp_q;
        rv_d = 1'b0;
        if (req_valid && req_burst) begin
            // no-wrap start must be even and not lie in the page tail (column bits 9:1 all ones)
            if (shadow_q[mrbo_pkg::WRAP_BIT]
                && (req_col[0] || req_col[9:1] == 9'h1ff)) begin
                ref_d = 1'b1;
            end else begin
                breq_d = 1'b1;
                col_d = {req_col[10:1], 1'b0};
                ap_d = req_auto_pre;
            end
        end else if (req_valid && req_write) begin
            if (!writable(req_addr) || (req_addr ==
                mrbo_pkg::MA_BURST_FEATURE_CONFIG && !feat_ok(clean))) begin
                ref_d = 1'b1;
            end else begin
                cmd_d = 2'(mrbo_pkg::MRBO_CMD_WRITE);
                addr_d = req_addr;
                wdata_d = req_addr == mrbo_pkg::MA_BURST_FEATURE_CONFIG ?
                    clean : 8'h00;
                if (req_addr == mrbo_pkg::MA_BURST_FEATURE_CONFIG) begin
                    shadow_d = clean;
                end
            end
        end else if (req_valid) begin
            cmd_d = 2'(mrbo_pkg::MRBO_CMD_READ);
            addr_d = req_addr;
        end
        if (link.rdata_valid) begin
            resp_d = link.rdata;
            rv_d = 1'b1;
        end
    end

    // host registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cmd_q <= 2'(mrbo_pkg::MRBO_CMD_NONE);
            addr_q <= '0;
            wdata_q <= '0;
            breq_q <= 1'b0;
            col_q <= '0;
            ap_q <= 1'b0;
            shadow_q <= mrbo_pkg::FEATURE_RESET;
            ref_q <= 1'b0;
            resp_q <= '0;
            rv_q <= 1'b0;
        end else begin
            cmd_q <= cmd_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            breq_q <= breq_d;
            col_q <= col_d;
            ap_q <= ap_d;
            shadow_q <= shadow_d;
            ref_q <= ref_d;
            resp_q <= resp_d;
            rv_q <= rv_d;
        end
    end

    assign link.cmd = cmd_q;
    assign link.addr = addr_q;
    assign link.wdata = wdata_q;
    assign link.burst_req = breq_q;
    assign link.col = col_q;
    assign link.auto_pre = ap_q;
    assign req_refused = ref_q;
    assign resp_data = resp_q;
    assign resp_valid = rv_q;
endmodule

// File: src/mrbo_link_if.sv
// interface: command/address and data between host and device
interface mrbo_link_if;
    logic [1:0] cmd;       // mrbo_pkg::mrbo_cmd_t value
    logic [7:0] addr;      // mode register address
    logic [7:0] wdata;     // write operand
    logic [7:0] rdata;     // read answer
    logic rdata_valid;     // answer valid, one cycle
    logic strobe_toggle;   // data strobe activity on every read answer
    logic burst_req;       // column burst request
    logic [10:0] col;      // column address, bit 0 driven zero by the host
    logic auto_pre;        // auto precharge after any burst, read or write
    logic [3:0] beat_col;  // per-beat burst column address
    logic beat_valid;
    logic beat_last;
    logic burst_illegal;   // illegal combination flagged
    logic precharge_start; // internal precharge start pulse
    modport device (
        input cmd, addr, wdata, burst_req, col, auto_pre,
        output rdata, rdata_valid, strobe_toggle, beat_col, beat_valid,
        beat_last, burst_illegal, precharge_start
    );
    modport host (
        output cmd, addr, wdata, burst_req, col, auto_pre,
        input rdata, rdata_valid, strobe_toggle, beat_col, beat_valid,
        beat_last, burst_illegal, precharge_start
    );
endinterface

// File: src/mrbo_pkg.sv
// package: mode register map, feature fields, burst constants
package mrbo_pkg;
    // mode register addresses
    localparam logic [7:0] MA_DEVICE_INFORMATION = 8'h00;
    localparam logic [7:0] MA_BURST_FEATURE_CONFIG = 8'h01;
    localparam logic [7:0] MA_FEATURE2 = 8'h02;
    localparam logic [7:0] MA_IO_CONFIG = 8'h03;
    localparam logic [7:0] MA_BANK_MASK = 8'h10;
    localparam logic [7:0] MA_LAST_DEFINED = 8'h11;
    // device information bits
    localparam int DI_CLASS_BIT = 1;
    localparam int DI_INIT_BIT = 0;
    localparam logic DI_CLASS_SDRAM = 1'h0;
    // feature register field positions
    localparam int BLEN_LSB = 0;
    localparam int BTYPE_BIT = 3;
    localparam int WRAP_BIT = 4;
    localparam int WR_LSB = 5;
    // burst length codes
    localparam logic [2:0] BL_CODE_4 = 3'h2;
    localparam logic [2:0] BL_CODE_8 = 3'h3;
    localparam logic [2:0] BL_CODE_16 = 3'h4;
    // write recovery codes and count offset
    localparam logic [2:0] WR_CODE_MIN = 3'h1;
    localparam logic [2:0] WR_CODE_MAX = 3'h6;
    localparam logic [3:0] WR_COUNT_OFFSET = 4'h2;
    // reset value: wr 3, wrap, sequential, bl4
    localparam logic [7:0] FEATURE_RESET = 8'h22;
    // beat counts
    localparam logic [4:0] BEATS_4 = 5'h04;
    localparam logic [4:0] BEATS_8 = 5'h08;
    localparam logic [4:0] BEATS_16 = 5'h10;
    // read countdown loaded on a read command (data valid three cycles after the command)
    localparam logic [1:0] READ_DELAY = 2'h2;
    // write recovery time for the host, ns, and clock period in ns
    localparam int T_WR_NS = 15;
    localparam int T_CK_NS = 25;
    localparam logic [2:0] WR_HOST_CODE = 3'((T_WR_NS + T_CK_NS - 1)
        / T_CK_NS + 0) < 3'h3 ? WR_CODE_MIN :
        3'(((T_WR_NS + T_CK_NS - 1) / T_CK_NS) - 2);
    typedef enum logic [1:0] {
        MRBO_CMD_NONE,
        MRBO_CMD_READ,
        MRBO_CMD_WRITE
    } mrbo_cmd_t;
endpackage
